// ===== hdl/ebpr_pkg.sv
package ebpr_pkg;

  // register port
  localparam int         ADDR_W       = 4;
  localparam int         DATA_W       = 16;
  localparam logic [3:0] ROUTE_OFS    = 4'h0;
  localparam logic [3:0] STATUS_OFS   = 4'h1;

  // route register fields
  localparam int PP_LSB   = 12;
  localparam int PP_MSB   = 14;
  localparam int SP1_LSB  = 10;
  localparam int SP1_MSB  = 11;
  localparam int SP0_LSB  = 8;
  localparam int SP0_MSB  = 9;
  localparam int ADDR_MSB = 5;

  localparam logic [15:0] ROUTE_RST   = 16'h0000;
  // reserved bits 15, 7 and 6 stay zero
  localparam logic [15:0] ROUTE_WMASK = 16'h7f3f;

  // status register bits
  localparam int ST_PP_RSVD  = 0;
  localparam int ST_SP1_RSVD = 1;
  localparam int ST_SP0_RSVD = 2;
  localparam int ST_CHANGED  = 3;
  localparam logic CHANGED_RST = 1'b0;

  // parallel-port route codes
  localparam logic [2:0] PP_GP            = 3'h0;
  localparam logic [2:0] PP_SPI_UART      = 3'h1;
  localparam logic [2:0] PP_PIX_GP        = 3'h2;
  localparam logic [2:0] PP_PIX_SPI_ASU3  = 3'h3;
  localparam logic [2:0] PP_PIX_ASU2_UART = 3'h4;
  localparam logic [2:0] PP_PIX_SPI_UART  = 3'h5;
  localparam logic [2:0] PP_SPI_ASU       = 3'h6;
  localparam logic [2:0] PP_RSVD          = 3'h7;

  // serial-port route codes
  localparam logic [1:0] SP_CARD   = 2'h0;
  localparam logic [1:0] SP_ASU_GP = 2'h1;
  localparam logic [1:0] SP_GP     = 2'h2;
  localparam logic [1:0] SP_RSVD   = 2'h3;

  // widths
  localparam int PP_PINS = 21;
  localparam int SP_PINS = 6;
  localparam int GP_W    = 32;

endpackage

// ===== hdl/ebpr_sync2.sv
`timescale 1ns/1ps
module ebpr_sync2 #(
  parameter int W = 1
) (
  input  wire logic         ref_clk,  // system clock
  input  wire logic         srst,     // sync reset
  input  wire logic [W-1:0] d,        // asynchronous level
  output logic      [W-1:0] q         // synchronised level
);
  logic [W-1:0] s1_q;
  logic [W-1:0] s2_q;

  // first stage feeds only the second
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      s1_q <= '0;
      s2_q <= '0;
    end else begin
      s1_q <= d;
      s2_q <= s1_q;
    end
  end

  assign q = s2_q;
endmodule

// ===== hdl/ebpr_router.sv
`timescale 1ns/1ps
// Behaviour
// R01: 3-bit parallel route field at bits 14:12
// R02: code 001: spi, six gp, uart, unit2
// R03: code 010: pixel data and eight gp
// R04: code 100: pixel, unit2, uart
// R05: code 101: pixel, four spi, uart
// R06: code 110: spi, units 2/3, six gp
// R07: pixel modes have no display behind them
// R08: 2-bit serial port 1 field, bits 11:10
// R09: port1 code 01: unit1 plus gp 11:10
// R10: 2-bit serial port 0 field, bits 9:8
// R11: port1 code 00: all six card1 signals
// R12: port1 code 10: gp 11 down to 6
// R13: gate, change once, then reset peripherals; the code only sets a sticky changed flag when bits 14:8 change
// R14: reserved codes must not be written; the code stores them, releases the pins and flags them in the status register
module ebpr_router (
  input  wire logic        ref_clk,     // 50 MHz system clock
  input  wire logic        srst,        // sync reset, high
  input  wire logic [3:0]  reg_addr,    // register index
  input  wire logic [15:0] reg_wdata,   // write data
  input  wire logic        reg_wr,      // write strobe
  input  wire logic        reg_rd,      // read strobe
  output logic      [15:0] reg_rdata,   // read data, cycle after rd
  output logic      [20:0] pp_pin_o,    // parallel pins out
  output logic      [20:0] pp_pin_oe_n, // parallel pins drive, low
  input  wire logic [20:0] pp_pin_i,    // parallel pins in
  output logic      [5:0]  sp1_pin_o,   // serial port 1 pins out
  output logic      [5:0]  sp1_pin_oe_n,// serial port 1 drive, low
  input  wire logic [5:0]  sp1_pin_i,   // serial port 1 pins in
  output logic      [5:0]  sp0_pin_o,   // serial port 0 pins out
  output logic      [5:0]  sp0_pin_oe_n,// serial port 0 drive, low
  input  wire logic [5:0]  sp0_pin_i,   // serial port 0 pins in
  input  wire logic [6:0]  spi_o,       // spi outputs
  input  wire logic [6:0]  spi_oe_n,    // spi drive, low
  output logic      [6:0]  spi_i,       // spi inputs
  input  wire logic [3:0]  uart_o,      // uart outputs
  input  wire logic [3:0]  uart_oe_n,   // uart drive, low
  output logic      [3:0]  uart_i,      // uart inputs
  input  wire logic [3:0]  asu2_o,      // audio unit 2 outputs
  input  wire logic [3:0]  asu2_oe_n,   // audio unit 2 drive, low
  output logic      [3:0]  asu2_i,      // audio unit 2 inputs
  input  wire logic [3:0]  asu3_o,      // audio unit 3 outputs
  input  wire logic [3:0]  asu3_oe_n,   // audio unit 3 drive, low
  output logic      [3:0]  asu3_i,      // audio unit 3 inputs
  input  wire logic [7:0]  pix_o,       // pixel data outputs
  input  wire logic [7:0]  pix_oe_n,    // pixel drive, low
  input  wire logic [3:0]  asu1_o,      // audio unit 1 outputs
  input  wire logic [3:0]  asu1_oe_n,   // audio unit 1 drive, low
  output logic      [3:0]  asu1_i,      // audio unit 1 inputs
  input  wire logic [3:0]  asu0_o,      // audio unit 0 outputs
  input  wire logic [3:0]  asu0_oe_n,   // audio unit 0 drive, low
  output logic      [3:0]  asu0_i,      // audio unit 0 inputs
  input  wire logic [5:0]  card1_o,     // card host 1 outputs
  input  wire logic [5:0]  card1_oe_n,  // card host 1 drive, low
  output logic      [5:0]  card1_i,     // card host 1 inputs
  input  wire logic [5:0]  card0_o,     // card host 0 outputs
  input  wire logic [5:0]  card0_oe_n,  // card host 0 drive, low
  output logic      [5:0]  card0_i,     // card host 0 inputs
  input  wire logic [31:0] gp_o,        // general pin outputs
  input  wire logic [31:0] gp_oe_n,     // general pin drive, low
  output logic      [31:0] gp_i         // general pin inputs
);

  logic [15:0] route_q, route_d;
  logic        changed_q, changed_d;
  logic [15:0] rdata_q, rdata_d;
  logic [2:0]  pp_sel;
  logic [1:0]  sp1_sel, sp0_sel;
  logic [20:0] pp_s;
  logic [5:0]  sp1_s, sp0_s;
  logic [20:0] pp_o_q, pp_o_d, pp_oen_q, pp_oen_d;
  logic [5:0]  sp1_o_q, sp1_o_d, sp1_oen_q, sp1_oen_d;
  logic [5:0]  sp0_o_q, sp0_o_d, sp0_oen_q, sp0_oen_d;
  logic [6:0]  spi_i_q, spi_i_d;
  logic [3:0]  uart_i_q, uart_i_d, asu2_i_q, asu2_i_d;
  logic [3:0]  asu3_i_q, asu3_i_d, asu1_i_q, asu1_i_d;
  logic [3:0]  asu0_i_q, asu0_i_d;
  logic [5:0]  card1_i_q, card1_i_d, card0_i_q, card0_i_d;
  logic [31:0] gp_i_q, gp_i_d;

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (srst);

  // pins come from outside the clock domain
  ebpr_sync2 #(.W(33)) u_pin_sync (
    .ref_clk (ref_clk),
    .srst    (srst),
    .d       ({pp_pin_i, sp1_pin_i, sp0_pin_i}),
    .q       ({pp_s, sp1_s, sp0_s})
  );

  assign pp_sel  = route_q[ebpr_pkg::PP_MSB:ebpr_pkg::PP_LSB];   // [R01]
  assign sp1_sel = route_q[ebpr_pkg::SP1_MSB:ebpr_pkg::SP1_LSB]; // [R08]
  assign sp0_sel = route_q[ebpr_pkg::SP0_MSB:ebpr_pkg::SP0_LSB]; // [R10]

  // register file
  always_comb begin
    route_d   = route_q;
    changed_d = changed_q;
    rdata_d   = 16'h0000;
    if (reg_wr && reg_addr == ebpr_pkg::ROUTE_OFS) begin
      route_d = reg_wdata & ebpr_pkg::ROUTE_WMASK;
      // sticky: software is expected to reroute only once after boot
      if (route_d[14:8] != route_q[14:8]) begin
        changed_d = 1'b1; // [R13]
      end
    end
    if (reg_rd) begin
      unique case (reg_addr)
        ebpr_pkg::ROUTE_OFS:  rdata_d = route_q;
        ebpr_pkg::STATUS_OFS: begin
          rdata_d[ebpr_pkg::ST_PP_RSVD]  = (pp_sel == ebpr_pkg::PP_RSVD);
          rdata_d[ebpr_pkg::ST_SP1_RSVD] = (sp1_sel == ebpr_pkg::SP_RSVD);
          rdata_d[ebpr_pkg::ST_SP0_RSVD] = (sp0_sel == ebpr_pkg::SP_RSVD);
          rdata_d[ebpr_pkg::ST_CHANGED]  = changed_q;
        end
        default: rdata_d = 16'h0000;
      endcase
    end
  end

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      route_q   <= ebpr_pkg::ROUTE_RST;
      changed_q <= ebpr_pkg::CHANGED_RST;
      rdata_q   <= 16'h0000;
    end else begin
      route_q   <= route_d;
      changed_q <= changed_d;
      rdata_q   <= rdata_d;
    end
  end

  // pin routing; unrouted pins are released, unrouted inputs read zero
  always_comb begin
    pp_o_d    = '0;
    pp_oen_d  = '1;
    sp1_o_d   = '0;
    sp1_oen_d = '1;
    sp0_o_d   = '0;
    sp0_oen_d = '1;
    spi_i_d   = '0;
    uart_i_d  = '0;
    asu2_i_d  = '0;
    asu3_i_d  = '0;
    asu1_i_d  = '0;
    asu0_i_d  = '0;
    card1_i_d = '0;
    card0_i_d = '0;
    gp_i_d    = '0;
    unique case (pp_sel)
      ebpr_pkg::PP_GP: begin
        pp_o_d[19:0]   = gp_o[31:12];
        pp_oen_d[19:0] = gp_oe_n[31:12];
        gp_i_d[31:12]  = pp_s[19:0];
      end
      ebpr_pkg::PP_SPI_UART: begin
        pp_o_d    = {asu2_o, uart_o, gp_o[17:12], spi_o};          // [R02]
        pp_oen_d  = {asu2_oe_n, uart_oe_n, gp_oe_n[17:12], spi_oe_n};
        spi_i_d        = pp_s[6:0];
        gp_i_d[17:12]  = pp_s[12:7];
        uart_i_d       = pp_s[16:13];
        asu2_i_d       = pp_s[20:17];
      end
      ebpr_pkg::PP_PIX_GP: begin
        // pixel modes drive pins only; no display block answers here
        pp_o_d[15:0]   = {gp_o[19:12], pix_o};                      // [R03]
        pp_oen_d[15:0] = {gp_oe_n[19:12], pix_oe_n};
        gp_i_d[19:12]  = pp_s[15:8];
      end
      ebpr_pkg::PP_PIX_SPI_ASU3: begin
        pp_o_d[15:0]   = {asu3_o, spi_o[3:0], pix_o};
        pp_oen_d[15:0] = {asu3_oe_n, spi_oe_n[3:0], pix_oe_n};
        spi_i_d[3:0]   = pp_s[11:8];
        asu3_i_d       = pp_s[15:12];
      end
      ebpr_pkg::PP_PIX_ASU2_UART: begin
        pp_o_d[15:0]   = {uart_o, asu2_o, pix_o};                  // [R04]
        pp_oen_d[15:0] = {uart_oe_n, asu2_oe_n, pix_oe_n};
        asu2_i_d       = pp_s[11:8];
        uart_i_d       = pp_s[15:12];
      end
      ebpr_pkg::PP_PIX_SPI_UART: begin
        pp_o_d[15:0]   = {uart_o, spi_o[3:0], pix_o};              // [R05]
        pp_oen_d[15:0] = {uart_oe_n, spi_oe_n[3:0], pix_oe_n};
        spi_i_d[3:0]   = pp_s[11:8];
        uart_i_d       = pp_s[15:12];
      end
      ebpr_pkg::PP_SPI_ASU: begin
        pp_o_d    = {gp_o[17:12], asu3_o, asu2_o, spi_o};          // [R06]
        pp_oen_d  = {gp_oe_n[17:12], asu3_oe_n, asu2_oe_n, spi_oe_n};
        spi_i_d        = pp_s[6:0];
        asu2_i_d       = pp_s[10:7];
        asu3_i_d       = pp_s[14:11];
        gp_i_d[17:12]  = pp_s[20:15];
      end
      ebpr_pkg::PP_RSVD: begin
        pp_o_d   = '0;                                             // [R14]
        pp_oen_d = '1;
      end
    endcase
    unique case (sp1_sel)
      ebpr_pkg::SP_CARD: begin
        sp1_o_d   = card1_o;                                       // [R11]
        sp1_oen_d = card1_oe_n;
        card1_i_d = sp1_s;
      end
      ebpr_pkg::SP_ASU_GP: begin
        sp1_o_d        = {gp_o[11:10], asu1_o};                    // [R09]
        sp1_oen_d      = {gp_oe_n[11:10], asu1_oe_n};
        asu1_i_d       = sp1_s[3:0];
        gp_i_d[11:10]  = sp1_s[5:4];
      end
      ebpr_pkg::SP_GP: begin
        sp1_o_d       = gp_o[11:6];                                // [R12]
        sp1_oen_d     = gp_oe_n[11:6];
        gp_i_d[11:6]  = sp1_s;
      end
      ebpr_pkg::SP_RSVD: begin
        sp1_oen_d = '1;                                            // [R14]
      end
    endcase
    unique case (sp0_sel)
      ebpr_pkg::SP_CARD: begin
        sp0_o_d   = card0_o;                                       // [R10]
        sp0_oen_d = card0_oe_n;
        card0_i_d = sp0_s;
      end
      ebpr_pkg::SP_ASU_GP: begin
        sp0_o_d      = {gp_o[5:4], asu0_o};
        sp0_oen_d    = {gp_oe_n[5:4], asu0_oe_n};
        asu0_i_d     = sp0_s[3:0];
        gp_i_d[5:4]  = sp0_s[5:4];
      end
      ebpr_pkg::SP_GP: begin
        sp0_o_d      = gp_o[5:0];
        sp0_oen_d    = gp_oe_n[5:0];
        gp_i_d[5:0]  = sp0_s;
      end
      ebpr_pkg::SP_RSVD: begin
        sp0_oen_d = '1;                                            // [R14]
      end
    endcase
  end

  // outbound paths are one flop deep; inbound paths add the two sync flops, three in all
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      pp_o_q    <= '0;
      pp_oen_q  <= '1;
      sp1_o_q   <= '0;
      sp1_oen_q <= '1;
      sp0_o_q   <= '0;
      sp0_oen_q <= '1;
      spi_i_q   <= '0;
      uart_i_q  <= '0;
      asu2_i_q  <= '0;
      asu3_i_q  <= '0;
      asu1_i_q  <= '0;
      asu0_i_q  <= '0;
      card1_i_q <= '0;
      card0_i_q <= '0;
      gp_i_q    <= '0;
    end else begin
      pp_o_q    <= pp_o_d;
      pp_oen_q  <= pp_oen_d;
      sp1_o_q   <= sp1_o_d;
      sp1_oen_q <= sp1_oen_d;
      sp0_o_q   <= sp0_o_d;
      sp0_oen_q <= sp0_oen_d;
      spi_i_q   <= spi_i_d;
      uart_i_q  <= uart_i_d;
      asu2_i_q  <= asu2_i_d;
      asu3_i_q  <= asu3_i_d;
      asu1_i_q  <= asu1_i_d;
      asu0_i_q  <= asu0_i_d;
      card1_i_q <= card1_i_d;
      card0_i_q <= card0_i_d;
      gp_i_q    <= gp_i_d;
    end
  end

  assign reg_rdata    = rdata_q;
  assign pp_pin_o     = pp_o_q;
  assign pp_pin_oe_n  = pp_oen_q;
  assign sp1_pin_o    = sp1_o_q;
  assign sp1_pin_oe_n = sp1_oen_q;
  assign sp0_pin_o    = sp0_o_q;
  assign sp0_pin_oe_n = sp0_oen_q;
  assign spi_i        = spi_i_q;
  assign uart_i       = uart_i_q;
  assign asu2_i       = asu2_i_q;
  assign asu3_i       = asu3_i_q;
  assign asu1_i       = asu1_i_q;
  assign asu0_i       = asu0_i_q;
  assign card1_i      = card1_i_q;
  assign card0_i      = card0_i_q;
  assign gp_i         = gp_i_q;

  sequence s_route_write;
    reg_wr && reg_addr == ebpr_pkg::ROUTE_OFS;
  endsequence
  sequence s_route_read;
    reg_rd && reg_addr == ebpr_pkg::ROUTE_OFS;
  endsequence

  property p_pp_field;
    s_route_write |=> pp_sel == $past(reg_wdata[14:12]);
  endproperty
  a_pp_field: assert property (p_pp_field) // [R01]
    else $error("parallel route field not taken from bits 14:12");

  property p_field_readback;
    s_route_write ##1 s_route_read |=>
      reg_rdata[14:8] == $past(reg_wdata[14:8], 2);
  endproperty
  a_field_readback: assert property (p_field_readback) // [R08]
    else $error("route fields do not read back as written");

  property p_spi_uart_out;
    pp_sel == ebpr_pkg::PP_SPI_UART |=>
      pp_pin_o[6:0] == $past(spi_o) && pp_pin_o[16:13] == $past(uart_o)
      && pp_pin_oe_n[20:17] == $past(asu2_oe_n);
  endproperty
  a_spi_uart_out: assert property (p_spi_uart_out) // [R02]
    else $error("code 001 pin routing wrong");

  property p_pix_gp;
    pp_sel == ebpr_pkg::PP_PIX_GP |=>
      pp_pin_o[15:0] == $past({gp_o[19:12], pix_o})
      && pp_pin_oe_n[20:16] == 5'h1f;
  endproperty
  a_pix_gp: assert property (p_pix_gp) // [R03]
    else $error("code 010 pin routing wrong");

  property p_pix_asu2_in;
    pp_sel == ebpr_pkg::PP_PIX_ASU2_UART [*3] |=>
      asu2_i == $past(pp_pin_i[11:8], 3) && spi_i == 7'h00;
  endproperty
  a_pix_asu2_in: assert property (p_pix_asu2_in) // [R04]
    else $error("code 100 input path wrong");

  property p_pix_spi_uart;
    pp_sel == ebpr_pkg::PP_PIX_SPI_UART |=>
      pp_pin_o[15:8] == $past({uart_o, spi_o[3:0]});
  endproperty
  a_pix_spi_uart: assert property (p_pix_spi_uart) // [R05]
    else $error("code 101 pin routing wrong");

  property p_spi_asu_in;
    pp_sel == ebpr_pkg::PP_SPI_ASU [*3] |=>
      asu3_i == $past(pp_pin_i[14:11], 3)
      && gp_i[17:12] == $past(pp_pin_i[20:15], 3);
  endproperty
  a_spi_asu_in: assert property (p_spi_asu_in) // [R06]
    else $error("code 110 input path wrong");

  property p_sp1_asu;
    sp1_sel == ebpr_pkg::SP_ASU_GP |=>
      sp1_pin_o == $past({gp_o[11:10], asu1_o});
  endproperty
  a_sp1_asu: assert property (p_sp1_asu) // [R09]
    else $error("serial port 1 code 01 routing wrong");

  property p_sp1_card_in;
    sp1_sel == ebpr_pkg::SP_CARD [*3] |=>
      card1_i == $past(sp1_pin_i, 3);
  endproperty
  a_sp1_card_in: assert property (p_sp1_card_in) // [R11]
    else $error("serial port 1 card input path wrong");

  property p_sp1_gp;
    sp1_sel == ebpr_pkg::SP_GP |=>
      sp1_pin_oe_n == $past(gp_oe_n[11:6]);
  endproperty
  a_sp1_gp: assert property (p_sp1_gp) // [R12]
    else $error("serial port 1 code 10 routing wrong");

  property p_sp0_field;
    s_route_write |=> sp0_sel == $past(reg_wdata[9:8]) ##1
      ($past(sp0_sel) != ebpr_pkg::SP_CARD ||
       sp0_pin_o == $past(card0_o));
  endproperty
  a_sp0_field: assert property (p_sp0_field) // [R10]
    else $error("serial port 0 field or routing wrong");

endmodule

// ===== testbench/ebpr_pin_model.sv
`timescale 1ns/1ps
// wire level of one shared port: the router, an outside device, pull-ups
module ebpr_pin_model #(
  parameter int W = 6
) (
  input  wire logic [W-1:0] pin_o,     // router pin value
  input  wire logic [W-1:0] pin_oe_n,  // router drive, low
  input  wire logic [W-1:0] ext_v,     // outside device value
  input  wire logic [W-1:0] ext_oe_n,  // outside device drive, low
  output logic      [W-1:0] pin_i      // level seen on the wire
);
  // a floating pin settles high on its pull-up, never on a stale value
  always_comb begin
    for (int k = 0; k < W; k++) begin
      if (!pin_oe_n[k]) begin
        pin_i[k] = pin_o[k];
      end else if (!ext_oe_n[k]) begin
        pin_i[k] = ext_v[k];
      end else begin
        pin_i[k] = 1'b1;
      end
    end
  end
endmodule

// ===== testbench/external_bus_pin_router_bench.sv
`timescale 1ns/1ps
module external_bus_pin_router_bench;
  logic        ref_clk = 1'b0, srst = 1'b1, reg_wr = 1'b0, reg_rd = 1'b0;
  logic [3:0]  reg_addr = 4'h0;
  logic [15:0] reg_wdata = 16'h0, reg_rdata;
  logic [20:0] pp_o, pp_oe_n, pp_i, pp_ext = 21'h1a5c3e, pp_eoe = '1;
  logic [5:0]  s1_o, s1_oe_n, s1_i, s1_ext = 6'h2d, s1_eoe = '1;
  logic [5:0]  s0_o, s0_oe_n, s0_i, s0_ext = 6'h13, s0_eoe = '1;
  logic [6:0]  spi_o = 7'h5a, spi_oe_n = '0, spi_i;
  logic [3:0]  uart_o = 4'h9, uart_oe_n = '0, uart_i;
  logic [3:0]  asu2_o = 4'h6, asu2_oe_n = '0, asu2_i;
  logic [3:0]  asu3_o = 4'hc, asu3_oe_n = '0, asu3_i;
  logic [3:0]  asu1_o = 4'h3, asu1_oe_n = '0, asu1_i;
  logic [3:0]  asu0_o = 4'he, asu0_oe_n = '0, asu0_i;
  logic [7:0]  pix_o = 8'ha7, pix_oe_n = '0;
  logic [5:0]  card1_o = 6'h2b, card1_oe_n = '0, card1_i;
  logic [5:0]  card0_o = 6'h15, card0_oe_n = '0, card0_i;
  logic [31:0] gp_o = 32'hc3a596e1, gp_oe_n = '0, gp_i;
  int          n_fail = 0, checks_done = 0;
  logic [2:0]  pm;
  logic [1:0]  s1, s0;

  always #10 ref_clk = ~ref_clk;

  ebpr_router dut_u (
    .ref_clk(ref_clk), .srst(srst), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata),
    .pp_pin_o(pp_o), .pp_pin_oe_n(pp_oe_n), .pp_pin_i(pp_i),
    .sp1_pin_o(s1_o), .sp1_pin_oe_n(s1_oe_n), .sp1_pin_i(s1_i),
    .sp0_pin_o(s0_o), .sp0_pin_oe_n(s0_oe_n), .sp0_pin_i(s0_i),
    .spi_o(spi_o), .spi_oe_n(spi_oe_n), .spi_i(spi_i),
    .uart_o(uart_o), .uart_oe_n(uart_oe_n), .uart_i(uart_i),
    .asu2_o(asu2_o), .asu2_oe_n(asu2_oe_n), .asu2_i(asu2_i),
    .asu3_o(asu3_o), .asu3_oe_n(asu3_oe_n), .asu3_i(asu3_i),
    .pix_o(pix_o), .pix_oe_n(pix_oe_n),
    .asu1_o(asu1_o), .asu1_oe_n(asu1_oe_n), .asu1_i(asu1_i),
    .asu0_o(asu0_o), .asu0_oe_n(asu0_oe_n), .asu0_i(asu0_i),
    .card1_o(card1_o), .card1_oe_n(card1_oe_n), .card1_i(card1_i),
    .card0_o(card0_o), .card0_oe_n(card0_oe_n), .card0_i(card0_i),
    .gp_o(gp_o), .gp_oe_n(gp_oe_n), .gp_i(gp_i)
  );

  ebpr_pin_model #(.W(21)) pp_m (
    .pin_o(pp_o), .pin_oe_n(pp_oe_n), .ext_v(pp_ext), .ext_oe_n(pp_eoe),
    .pin_i(pp_i)
  );
  ebpr_pin_model #(.W(6)) s1_m (
    .pin_o(s1_o), .pin_oe_n(s1_oe_n), .ext_v(s1_ext), .ext_oe_n(s1_eoe),
    .pin_i(s1_i)
  );
  ebpr_pin_model #(.W(6)) s0_m (
    .pin_o(s0_o), .pin_oe_n(s0_oe_n), .ext_v(s0_ext), .ext_oe_n(s0_eoe),
    .pin_i(s0_i)
  );

  task automatic check(input logic [63:0] seen, input logic [63:0] exp);
    checks_done++;
    if (seen !== exp) begin
      n_fail++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic close_out();
    $display("checks %0d mismatches %0d", checks_done, n_fail);
    if (n_fail == 0 && checks_done > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  task automatic reg_write(input logic [3:0] a, input logic [15:0] d);
    @(posedge ref_clk);
    reg_wr    <= 1'b1;
    reg_addr  <= a;
    reg_wdata <= d;
    @(posedge ref_clk);
    reg_wr    <= 1'b0;
  endtask

  // read data stand only in the cycle after the strobe, then fall to 0
  task automatic reg_read(input logic [3:0] a, input logic [15:0] exp);
    @(posedge ref_clk);
    reg_rd   <= 1'b1;
    reg_addr <= a;
    @(posedge ref_clk);
    reg_rd   <= 1'b0;
    #1;
    check(reg_rdata, exp);
    @(posedge ref_clk);
    #1;
    check(reg_rdata, 16'h0);
  endtask

  // write then read with no gap between the strobes
  task automatic reg_wr_rd(input logic [3:0] a, input logic [15:0] d,
                           input logic [15:0] exp);
    @(posedge ref_clk);
    reg_wr    <= 1'b1;
    reg_addr  <= a;
    reg_wdata <= d;
    @(posedge ref_clk);
    reg_wr    <= 1'b0;
    reg_rd    <= 1'b1;
    @(posedge ref_clk);
    reg_rd    <= 1'b0;
    #1;
    check(reg_rdata, exp);
    @(posedge ref_clk);
    #1;
    check(reg_rdata, 16'h0);
  endtask

  // expected {oe_n, o} of the parallel pins with every peripheral driving
  function automatic logic [41:0] exp_pp(input logic [2:0] m);
    logic [20:0] o;
    logic [20:0] z;
    o = 21'h0;
    z = 21'h1f0000;
    case (m)
      3'h0: begin
        o[19:0] = gp_o[31:12];
        z       = 21'h100000;
      end
      3'h1: begin
        o = {asu2_o, uart_o, gp_o[17:12], spi_o};
        z = 21'h0;
      end
      3'h2: o[15:0] = {gp_o[19:12], pix_o};
      3'h3: o[15:0] = {asu3_o, spi_o[3:0], pix_o};
      3'h4: o[15:0] = {uart_o, asu2_o, pix_o};
      3'h5: o[15:0] = {uart_o, spi_o[3:0], pix_o};
      3'h6: begin
        o = {gp_o[17:12], asu3_o, asu2_o, spi_o};
        z = 21'h0;
      end
      default: z = 21'h1fffff;
    endcase
    return {z, o};
  endfunction

  function automatic logic [11:0] exp_sp(input logic [1:0] m,
      input logic [5:0] card, input logic [3:0] asu, input logic [5:0] g6);
    logic [5:0] o;
    logic [5:0] z;
    o = 6'h0;
    z = 6'h0;
    case (m)
      2'h0: o = card;
      2'h1: o = {g6[5:4], asu};
      2'h2: o = g6;
      default: z = 6'h3f;
    endcase
    return {z, o};
  endfunction

  initial begin
    repeat (5000) @(posedge ref_clk);
    n_fail++;
    close_out();
  end

  initial begin
    repeat (2) @(posedge ref_clk);
    srst <= 1'b0;
    reg_read(ebpr_pkg::ROUTE_OFS, ebpr_pkg::ROUTE_RST);
    reg_read(ebpr_pkg::STATUS_OFS, 16'h0000);
    reg_write(4'h2, 16'hffff);
    reg_read(4'h2, 16'h0000);
    // reserved bits ignored; low bits alone leave the changed flag clear
    reg_write(ebpr_pkg::ROUTE_OFS, 16'h80ea);
    reg_read(ebpr_pkg::ROUTE_OFS, 16'h002a);
    reg_read(ebpr_pkg::STATUS_OFS, 16'h0000);
    // every code of each field; reserved codes are written on purpose
    // to see the pins released pixel pins carry data only
    for (int m = 0; m < 8; m++) begin
      pm = 3'(m);
      s1 = pm[1:0];
      s0 = ~pm[1:0];
      reg_wr_rd(ebpr_pkg::ROUTE_OFS, {1'b1, pm, s1, s0, 8'hc0},
                {1'b0, pm, s1, s0, 8'h00});
      reg_read(ebpr_pkg::STATUS_OFS,
               {12'h0, 1'b1, s0 == 2'h3, s1 == 2'h3, pm == 3'h7});
      repeat (2) @(posedge ref_clk);
      #1;
      check({pp_oe_n, pp_o}, exp_pp(pm));
      check({s1_oe_n, s1_o},
            exp_sp(s1, card1_o, asu1_o, gp_o[11:6]));
      check({s0_oe_n, s0_o},
            exp_sp(s0, card0_o, asu0_o, gp_o[5:0]));
    end
    // one cycle from peripheral output to pin
    reg_write(ebpr_pkg::ROUTE_OFS, 16'h1000);
    repeat (2) @(posedge ref_clk);
    spi_o <= 7'h2a;
    @(posedge ref_clk);
    #1;
    check(pp_o[6:0], 7'h2a);
    // inbound: peripherals release, outside devices drive the pins
    @(posedge ref_clk);
    {spi_oe_n, uart_oe_n, asu2_oe_n, asu3_oe_n, asu1_oe_n} <= '1;
    {asu0_oe_n, pix_oe_n, card1_oe_n, card0_oe_n, gp_oe_n} <= '1;
    {pp_eoe, s1_eoe, s0_eoe} <= '0;
    reg_write(ebpr_pkg::ROUTE_OFS, 16'h1600);
    repeat (5) @(posedge ref_clk);
    #1;
    check(pp_oe_n, 21'h1fffff);
    check({spi_i, uart_i, asu2_i},
          {pp_ext[6:0], pp_ext[16:13], pp_ext[20:17]});
    check({asu1_i, card1_i, card0_i}, {s1_ext[3:0], 12'h0});
    check(gp_i,
          {14'h0, pp_ext[12:7], s1_ext[5:4], 4'h0, s0_ext});
    reg_write(ebpr_pkg::ROUTE_OFS, 16'h6100);
    repeat (5) @(posedge ref_clk);
    #1;
    check({spi_i, asu2_i, asu3_i, uart_i},
          {pp_ext[6:0], pp_ext[10:7], pp_ext[14:11], 4'h0});
    check({card1_i, asu0_i, asu1_i},
          {s1_ext, s0_ext[3:0], 4'h0});
    check(gp_i,
          {14'h0, pp_ext[20:15], 6'h0, s0_ext[5:4], 4'h0});
    // pixel mode 100 inbound, port 1 on gp 11:6, port 0 on card 0
    reg_write(ebpr_pkg::ROUTE_OFS, 16'h4800);
    repeat (5) @(posedge ref_clk);
    #1;
    check({asu2_i, uart_i, spi_i},
          {pp_ext[11:8], pp_ext[15:12], 7'h00});
    check({card0_i, gp_i}, {s0_ext, 20'h0, s1_ext, 6'h0});
    // second reset in mid-run clears route and the changed flag
    @(posedge ref_clk);
    srst <= 1'b1;
    repeat (2) @(posedge ref_clk);
    srst <= 1'b0;
    reg_read(ebpr_pkg::ROUTE_OFS, 16'h0000);
    reg_read(ebpr_pkg::STATUS_OFS, 16'h0000);
    close_out();
  end
endmodule
